//--- io_port_cfg.svh
// constants for the port access unit: widths, field positions, depths
// assumes nothing beyond a preprocessor; included by bare name
`ifndef IO_PORT_CFG_SVH
`define IO_PORT_CFG_SVH

`define IO_PORT_ADDR_W 16
`define IO_DATA_W 16
`define IO_IMM_PORT_W 8
`define IO_DIR_FLAG_BIT 10
`define IO_FIFO_DEPTH 8
`define IO_BE_LOW 2'b01
`define IO_BE_HIGH 2'b10
`define IO_BE_WORD 2'b11

`endif

//--- io_port_pkg.sv
// types shared by the port access unit
// assumes io_port_cfg.svh is on the include path
package io_port_pkg;
    typedef enum logic [1:0] {
        OP_PORT_READ = 2'b00,
        OP_PORT_WRITE = 2'b01,
        OP_BLOCK_READ = 2'b10,
        OP_BLOCK_WRITE = 2'b11
    } io_op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FETCH = 3'b001,
        S_BUS = 3'b010,
        S_PUSH = 3'b011,
        S_STEP = 3'b100
    } io_state_t;
endpackage

//--- io_elem_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module io_elem_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] fill;
    logic do_push;
    logic do_pop;

    assign in_ready_o = (fill != (AW+1)'(DEPTH));
    assign out_valid_o = (fill != '0);
    assign out_data_o = mem[rd_ptr];
    assign do_push = in_valid_i && in_ready_o;
    assign do_pop = out_valid_o && out_ready_i;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    always_ff @(posedge core_clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (do_pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            if (do_push && !do_pop) begin
                fill <= fill + (AW+1)'(1);
            end else if (do_pop && !do_push) begin
                fill <= fill - (AW+1)'(1);
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_full_refuses: assert property (fill == (AW+1)'(DEPTH) |-> !in_ready_o && out_valid_o)
        else $error("fifo full but still accepting");
    a_empty_holds: assert property (fill == '0 && !do_push |=> !out_valid_o)
        else $error("fifo shows data while empty");
endmodule
`default_nettype wire

//--- io_port_access_unit.sv
// port access unit: single and block transfers in the byte-port space
// assumes the core supplies operands, fetches block source data and
// takes read results from the buffered result stream
//
// How it works
// - separate 64K byte-port space selected by a 16-bit port address
// - two consecutive byte ports act together as one word port
// - each access moves 8 or 16 bits; even word ports in one access
// - even byte ports use low data lines, odd ones use the upper lines
// - single transfers use the wide accumulator, or its low byte
// - single port address from 8-bit immediate or the port address register
// - block transfers: port from register, memory from source or destination index
// - index steps after each block element; port address stays constant
// - protected mode can forbid port instructions; otherwise modes identical
// - memory references of block transfers get normal protection checks
// - direction flag set steps index down, clear steps it up
`timescale 1ns/10ps
`default_nettype none
`include "io_port_cfg.svh"
module io_port_access_unit #(
    parameter int FIFO_DEPTH = `IO_FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // command from the core
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire io_port_pkg::io_op_t cmd_op_i,
    input wire logic cmd_word_i,
    input wire logic cmd_imm_sel_i,
    input wire logic [`IO_IMM_PORT_W-1:0] cmd_imm_port_i,
    input wire logic [15:0] block_count_i,
    // architectural state from the core
    input wire logic [15:0] port_address_register_i,
    input wire logic [15:0] wide_accumulator_i,
    input wire logic [15:0] source_index_register_i,
    input wire logic [15:0] destination_index_register_i,
    input wire logic [15:0] flags_word_i,
    input wire logic protected_mode_i,
    input wire logic io_allowed_i,
    input wire logic mem_fault_i,
    // completion
    output logic done_o,
    output logic fault_o,
    output logic [15:0] index_o,
    // block source data, fetched by the core at src_addr_o
    input wire logic src_valid_i,
    output logic src_ready_o,
    input wire logic [15:0] src_data_i,
    output logic [15:0] src_addr_o,
    // read results: data and memory address of each element
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [15:0] rd_data_o,
    output logic [15:0] rd_addr_o,
    // port bus
    output logic io_req_o,
    output logic io_we_o,
    output logic [`IO_PORT_ADDR_W-1:0] io_addr_o,
    output logic [1:0] io_be_o,
    output logic [`IO_DATA_W-1:0] io_wdata_o,
    input wire logic [`IO_DATA_W-1:0] io_rdata_i,
    input wire logic io_ack_i
);
    import io_port_pkg::*;

    io_state_t state;
    io_op_t op_q;
    logic word_q;
    logic imm_q;
    logic down_q;
    logic phase_q;
    logic [15:0] port_q;
    logic [15:0] idx_q;
    logic [15:0] cnt_q;
    logic [15:0] data_q;
    logic block_q;
    logic is_read;
    logic split;
    logic lane_hi;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [31:0] fifo_out;
    logic [7:0] sel_byte;
    logic port_op_ok;

    function automatic logic [15:0] step_index(input logic [15:0] idx, input logic word, input logic down);
        logic [15:0] amt;
        amt = word ? 16'h0002 : 16'h0001;
        step_index = down ? idx - amt : idx + amt;
    endfunction

    assign block_q = op_q[1];
    assign is_read = !op_q[0];
    assign split = word_q && port_q[0];
    assign lane_hi = port_q[0] ^ phase_q;
    assign port_op_ok = !protected_mode_i || io_allowed_i;
    assign cmd_ready_o = (state == S_IDLE);
    assign src_ready_o = (state == S_FETCH) && block_q && !is_read;
    assign src_addr_o = idx_q;
    assign index_o = idx_q;

    // bus phase: address and lanes come straight from held state
    assign io_req_o = (state == S_BUS);
    assign io_we_o = (state == S_BUS) && !is_read;
    assign io_addr_o = port_q + {15'h0000, phase_q};
    assign sel_byte = phase_q ? data_q[15:8] : data_q[7:0];
    always_comb begin
        if (word_q && !split) begin
            io_be_o = `IO_BE_WORD;
            io_wdata_o = data_q;
        end else if (lane_hi) begin
            io_be_o = `IO_BE_HIGH;
            io_wdata_o = {sel_byte, 8'h00};
        end else begin
            io_be_o = `IO_BE_LOW;
            io_wdata_o = {8'h00, sel_byte};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    if (cmd_valid_i && port_op_ok && !(cmd_op_i[1] && block_count_i == 16'h0000)) begin
                        state <= (cmd_op_i == OP_PORT_WRITE) ? S_BUS : S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (block_q && mem_fault_i) begin
                        state <= S_IDLE;
                    end else if (is_read ? fifo_in_ready : (!block_q || src_valid_i)) begin
                        state <= S_BUS;
                    end
                end
                S_BUS: begin
                    if (io_ack_i && !(split && !phase_q)) begin
                        state <= is_read ? S_PUSH : S_STEP;
                    end
                end
                S_PUSH: begin
                    if (fifo_in_ready) begin
                        state <= S_STEP;
                    end
                end
                S_STEP: begin
                    state <= (cnt_q == 16'h0001) ? S_IDLE : S_FETCH;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // command capture
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            op_q <= OP_PORT_READ;
            word_q <= 1'b0;
            imm_q <= 1'b0;
            down_q <= 1'b0;
            port_q <= 16'h0000;
            cnt_q <= 16'h0000;
        end else if (state == S_IDLE && cmd_valid_i) begin
            op_q <= cmd_op_i;
            word_q <= cmd_word_i;
            imm_q <= cmd_imm_sel_i && !cmd_op_i[1];
            down_q <= flags_word_i[`IO_DIR_FLAG_BIT];
            if (cmd_imm_sel_i && !cmd_op_i[1]) begin
                port_q <= {8'h00, cmd_imm_port_i};
            end else begin
                port_q <= port_address_register_i;
            end
            cnt_q <= cmd_op_i[1] ? block_count_i : 16'h0001;
        end else if (state == S_STEP) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    // memory index: picked per direction, stepped per element
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            idx_q <= 16'h0000;
        end else if (state == S_IDLE && cmd_valid_i) begin
            if (cmd_op_i == OP_BLOCK_READ) begin
                idx_q <= destination_index_register_i;
            end else if (cmd_op_i == OP_BLOCK_WRITE) begin
                idx_q <= source_index_register_i;
            end else begin
                idx_q <= 16'h0000;
            end
        end else if (state == S_STEP && block_q) begin
            idx_q <= step_index(idx_q, word_q, down_q);
        end
    end

    // element data and byte phase
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            data_q <= 16'h0000;
            phase_q <= 1'b0;
        end else if (state == S_IDLE && cmd_valid_i) begin
            data_q <= cmd_word_i ? wide_accumulator_i : {8'h00, wide_accumulator_i[7:0]};
            phase_q <= 1'b0;
        end else if (state == S_FETCH) begin
            phase_q <= 1'b0;
            if (src_ready_o && src_valid_i) begin
                data_q <= word_q ? src_data_i : {8'h00, src_data_i[7:0]};
            end
        end else if (state == S_BUS && io_ack_i) begin
            if (is_read) begin
                if (word_q && !split) begin
                    data_q <= io_rdata_i;
                end else if (!phase_q) begin
                    data_q <= {8'h00, lane_hi ? io_rdata_i[15:8] : io_rdata_i[7:0]};
                end else begin
                    data_q[15:8] <= lane_hi ? io_rdata_i[15:8] : io_rdata_i[7:0];
                end
            end
            if (split && !phase_q) begin
                phase_q <= 1'b1;
            end
        end
    end

    // completion pulses
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            done_o <= 1'b0;
            fault_o <= 1'b0;
        end else begin
            done_o <= (state == S_STEP && cnt_q == 16'h0001)
                || (state == S_IDLE && cmd_valid_i && port_op_ok && cmd_op_i[1] && block_count_i == 16'h0000);
            fault_o <= (state == S_IDLE && cmd_valid_i && !port_op_ok)
                || (state == S_FETCH && block_q && mem_fault_i);
        end
    end

    assign fifo_in_valid = (state == S_PUSH);

    io_elem_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_result_fifo (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i({idx_q, data_q}),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(fifo_out)
    );
    assign rd_data_o = fifo_out[15:0];
    assign rd_addr_o = fifo_out[31:16];

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_low_half;
        io_req_o && io_ack_i && split && !phase_q && io_addr_o == port_q;
    endsequence
    sequence s_high_half;
        io_req_o && io_addr_o == port_q + 16'h0001 && io_be_o == `IO_BE_LOW;
    endsequence

    a_odd_word_split: assert property (s_low_half |=> s_high_half)
        else $error("odd word access not followed by upper byte access");
    a_byte_lane: assert property (io_req_o && io_be_o != `IO_BE_WORD |-> io_be_o == (io_addr_o[0] ? `IO_BE_HIGH : `IO_BE_LOW))
        else $error("byte access on wrong data lane");
    a_word_even: assert property (io_req_o && io_be_o == `IO_BE_WORD |-> !io_addr_o[0])
        else $error("single word access at odd port");
    a_forbidden_op: assert property (state == S_IDLE && cmd_valid_i && !port_op_ok |=> fault_o && !io_req_o ##1 !io_req_o)
        else $error("forbidden port instruction reached the bus");
    a_imm_range: assert property (io_req_o && imm_q |-> io_addr_o[15:8] == 8'h00 || split)
        else $error("immediate port address beyond 256");
    a_port_fixed: assert property (state == S_STEP && block_q |=> $stable(port_q))
        else $error("port address changed during block transfer");
    a_index_step: assert property (state == S_STEP && block_q
        |=> idx_q == (down_q ? $past(idx_q) - (word_q ? 16'h0002 : 16'h0001) : $past(idx_q) + (word_q ? 16'h0002 : 16'h0001)))
        else $error("memory index stepped wrongly");
    a_req_held: assert property (io_req_o && !io_ack_i |=> io_req_o && $stable(io_addr_o) && $stable(io_be_o))
        else $error("port request dropped before acknowledge");
    a_mem_fault_stop: assert property (state == S_FETCH && block_q && mem_fault_i |=> fault_o && state == S_IDLE)
        else $error("memory fault did not stop block transfer");
endmodule
`default_nettype wire

//--- io_port_peripheral_model.sv
// peripheral model on the port bus: byte storage covering the whole port space
// assumes the unit holds each request steady until it sees the acknowledge
`timescale 1ns/10ps
`default_nettype none
module io_port_peripheral_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // port bus
    input wire logic io_req_i,
    input wire logic io_we_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [1:0] io_be_i,
    input wire logic [15:0] io_wdata_i,
    output logic [15:0] io_rdata_o,
    output logic io_ack_o,
    // answer delay in cycles
    input wire logic [3:0] dly_i
);
    logic [7:0] mem [0:65535];
    logic [15:0] acc_cnt;
    logic [15:0] rdat;
    logic [3:0] wait_cnt;
    logic [15:0] ev;

    // word registers sit on even pairs, the odd byte on the upper lane
    assign ev = {io_addr_i[15:1], 1'b0};
    // released data lines show the inverse of the last value
    assign io_rdata_o = io_ack_o ? rdat : ~rdat;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ 8'h5A;
        end
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            io_ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            acc_cnt <= 16'h0;
            rdat <= 16'h0;
        end else if (io_req_i && !io_ack_o && wait_cnt >= dly_i) begin
            io_ack_o <= 1'b1;
            wait_cnt <= 4'h0;
            acc_cnt <= acc_cnt + 16'h1;
            if (io_we_i) begin
                if (io_be_i[0]) mem[ev] <= io_wdata_i[7:0];
                if (io_be_i[1]) mem[ev + 16'h1] <= io_wdata_i[15:8];
            end else begin
                rdat <= {mem[ev + 16'h1], mem[ev]};
            end
        end else begin
            io_ack_o <= 1'b0;
            wait_cnt <= (io_req_i && !io_ack_o) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

//--- io_port_access_unit_bench.sv
// self-checking bench for the port access unit with a peripheral model
// assumes the design files and io_port_cfg.svh are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "io_port_cfg.svh"
module io_port_access_unit_bench;
    import io_port_pkg::*;
    logic core_clk_i, rst_b_i, cmd_valid_i, cmd_ready_o, cmd_word_i, cmd_imm_sel_i;
    io_op_t cmd_op_i;
    logic [7:0] cmd_imm_port_i;
    logic [15:0] block_count_i, port_address_register_i, wide_accumulator_i;
    logic [15:0] source_index_register_i, destination_index_register_i, flags_word_i;
    logic protected_mode_i, io_allowed_i, mem_fault_i, done_o, fault_o, src_valid_i, src_ready_o;
    logic [15:0] index_o, src_data_i, src_addr_o, rd_data_o, rd_addr_o, io_addr_o, io_wdata_o, io_rdata_i;
    logic rd_valid_o, rd_ready_i, io_req_o, io_we_o, io_ack_i;
    logic [1:0] io_be_o;
    logic [3:0] dly;
    logic [15:0] c0;
    int error_cnt, n_tests;
    int n_done = 0, n_fault = 0, d0, f0;

    io_port_access_unit #(.FIFO_DEPTH(`IO_FIFO_DEPTH)) u_dut (.*);

    io_port_peripheral_model u_per (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .io_req_i(io_req_o),
        .io_we_i(io_we_o),
        .io_addr_i(io_addr_o),
        .io_be_i(io_be_o),
        .io_wdata_i(io_wdata_o),
        .io_rdata_o(io_rdata_i),
        .io_ack_o(io_ack_i),
        .dly_i(dly)
    );

    // source data follows the fetch address so each element is traceable
    always @(negedge core_clk_i) begin
        src_data_i <= src_addr_o ^ 16'h7E7E;
    end

    // completion pulses are counted so a pulse during other work is not lost
    always @(posedge core_clk_i) begin
        if (done_o === 1'b1) n_done <= n_done + 1;
        if (fault_o === 1'b1) n_fault <= n_fault + 1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic issue(input io_op_t op, input logic w, input logic imm, input logic [15:0] port,
            input logic [15:0] v, input logic [15:0] cnt, input logic down);
        d0 = n_done;
        f0 = n_fault;
        @(negedge core_clk_i);
        cmd_op_i = op;
        cmd_word_i = w;
        cmd_imm_sel_i = imm;
        cmd_imm_port_i = port[7:0];
        port_address_register_i = imm ? 16'hFFFF : port;
        wide_accumulator_i = v;
        source_index_register_i = v;
        destination_index_register_i = v;
        block_count_i = cnt;
        flags_word_i = down ? 16'h0400 : 16'h0000;
        cmd_valid_i = 1'b1;
        while (cmd_ready_o !== 1'b1) @(negedge core_clk_i);
        @(negedge core_clk_i);
        cmd_valid_i = 1'b0;
    endtask

    task automatic wait_end(input logic ef);
        int k;
        k = 0;
        while (n_done == d0 && n_fault == f0 && k < 3000) begin
            @(negedge core_clk_i);
            k++;
        end
        @(negedge core_clk_i);
        check(16'(n_done - d0), {15'h0, ~ef});
        check(16'(n_fault - f0), {15'h0, ef});
    endtask

    task automatic pop(input logic [15:0] ed, input logic [15:0] ea);
        int k;
        k = 0;
        while (rd_valid_o !== 1'b1 && k < 3000) begin
            @(negedge core_clk_i);
            k++;
        end
        check({15'h0, rd_valid_o}, 16'h0001);
        check(rd_data_o, ed);
        check(rd_addr_o, ea);
        rd_ready_i = 1'b1;
        @(negedge core_clk_i);
        rd_ready_i = 1'b0;
        @(negedge core_clk_i);
    endtask

    task automatic t_single();
        c0 = u_per.acc_cnt;
        issue(OP_PORT_WRITE, 1'b0, 1'b1, 16'h0041, 16'h1234, 16'h0, 1'b0);
        wait_end(1'b0);
        check({8'h0, u_per.mem[16'h0041]}, 16'h0034);
        check({8'h0, u_per.mem[16'h0040]}, 16'h001A);
        issue(OP_PORT_WRITE, 1'b1, 1'b0, 16'h0300, 16'hBEEF, 16'h0, 1'b0);
        wait_end(1'b0);
        check(u_per.acc_cnt - c0, 16'h2);
        issue(OP_PORT_READ, 1'b1, 1'b0, 16'h0300, 16'h0000, 16'h0, 1'b0);
        wait_end(1'b0);
        pop(16'hBEEF, 16'h0000);
        issue(OP_PORT_WRITE, 1'b1, 1'b0, 16'h0501, 16'hA55A, 16'h0, 1'b0);
        wait_end(1'b0);
        check({u_per.mem[16'h0502], u_per.mem[16'h0501]}, 16'hA55A);
        check(u_per.acc_cnt - c0, 16'h5);
        issue(OP_PORT_READ, 1'b0, 1'b1, 16'h0007, 16'h0000, 16'h0, 1'b0);
        wait_end(1'b0);
        pop(16'h005D, 16'h0000);
    endtask

    task automatic t_block();
        c0 = u_per.acc_cnt;
        issue(OP_BLOCK_READ, 1'b0, 1'b0, 16'h0080, 16'h1000, 16'h3, 1'b1);
        wait_end(1'b0);
        check(index_o, 16'h0FFD);
        for (int i = 0; i < 3; i++) pop(16'h00DA, 16'h1000 - i[15:0]);
        src_valid_i = 1'b0;
        issue(OP_BLOCK_WRITE, 1'b1, 1'b0, 16'h0600, 16'h3000, 16'h2, 1'b0);
        repeat (10) @(negedge core_clk_i);
        check({15'h0, src_ready_o}, 16'h0001);
        check(u_per.acc_cnt - c0, 16'h3);
        src_valid_i = 1'b1;
        wait_end(1'b0);
        check({u_per.mem[16'h0601], u_per.mem[16'h0600]}, 16'h4E7C);
        check(index_o, 16'h3004);
        issue(OP_BLOCK_WRITE, 1'b1, 1'b0, 16'h0600, 16'h3000, 16'h0, 1'b0);
        wait_end(1'b0);
        check(u_per.acc_cnt - c0, 16'h5);
    endtask

    task automatic t_fifo();
        dly = 4'h3;
        c0 = u_per.acc_cnt;
        issue(OP_BLOCK_READ, 1'b1, 1'b0, 16'h0200, 16'h2000, 16'd10, 1'b0);
        repeat (200) @(negedge core_clk_i);
        check(u_per.acc_cnt - c0, 16'(`IO_FIFO_DEPTH));
        for (int i = 0; i < 9; i++) pop(16'h5B5A, 16'h2000 + 16'(2 * i));
        wait_end(1'b0);
        pop(16'h5B5A, 16'h2012);
        check(index_o, 16'h2014);
        dly = 4'h0;
    endtask

    task automatic t_protect();
        c0 = u_per.acc_cnt;
        protected_mode_i = 1'b1;
        io_allowed_i = 1'b0;
        issue(OP_PORT_WRITE, 1'b0, 1'b1, 16'h0042, 16'h0077, 16'h0, 1'b0);
        wait_end(1'b1);
        check(u_per.acc_cnt - c0, 16'h0);
        io_allowed_i = 1'b1;
        issue(OP_PORT_WRITE, 1'b0, 1'b1, 16'h0042, 16'h0077, 16'h0, 1'b0);
        wait_end(1'b0);
        check({8'h0, u_per.mem[16'h0042]}, 16'h0077);
        mem_fault_i = 1'b1;
        issue(OP_BLOCK_WRITE, 1'b0, 1'b0, 16'h0600, 16'h3000, 16'h2, 1'b0);
        wait_end(1'b1);
        check(u_per.acc_cnt - c0, 16'h1);
        mem_fault_i = 1'b0;
        protected_mode_i = 1'b0;
    endtask

    task automatic t_reset();
        issue(OP_BLOCK_READ, 1'b1, 1'b0, 16'h0200, 16'h2000, 16'd10, 1'b0);
        repeat (30) @(negedge core_clk_i);
        check({15'h0, rd_valid_o}, 16'h0001);
        rst_b_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        check({11'h0, cmd_ready_o, rd_valid_o, io_req_o, done_o, fault_o}, 16'h0010);
        check(index_o, 16'h0000);
        issue(OP_PORT_READ, 1'b0, 1'b1, 16'h0007, 16'h0000, 16'h0, 1'b0);
        wait_end(1'b0);
        pop(16'h005D, 16'h0000);
    endtask

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    initial begin
        error_cnt = 0;
        n_tests = 0;
        rst_b_i = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_op_i = OP_PORT_READ;
        cmd_word_i = 1'b0;
        cmd_imm_sel_i = 1'b0;
        cmd_imm_port_i = 8'h00;
        block_count_i = 16'h0;
        port_address_register_i = 16'h0;
        wide_accumulator_i = 16'h0;
        source_index_register_i = 16'h0;
        destination_index_register_i = 16'h0;
        flags_word_i = 16'h0;
        protected_mode_i = 1'b0;
        io_allowed_i = 1'b0;
        mem_fault_i = 1'b0;
        src_valid_i = 1'b1;
        rd_ready_i = 1'b0;
        dly = 4'h0;
        repeat (5) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        t_single();
        t_block();
        t_fifo();
        t_protect();
        t_reset();
        close_out();
    end

    initial begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
